// ===== cch_pkg.sv
package cch_pkg;

  // ==========================================================
  // command codes and trigger actions
  typedef enum logic [4:0] {
    CMD_CAL_Q, CMD_CLS, CMD_DDT, CMD_DMC, CMD_EMC, CMD_EMC_Q, CMD_ESE,
    CMD_ESE_Q, CMD_ESR_Q, CMD_GMC_Q, CMD_IDN_Q, CMD_LMC_Q, CMD_OPC,
    CMD_OPC_Q, CMD_OPT_Q, CMD_PMC, CMD_RCL, CMD_RST, CMD_SAV, CMD_SRE,
    CMD_SRE_Q, CMD_STB_Q, CMD_TRG, CMD_TST_Q, CMD_WAI, CMD_GET
  } cch_cmd_code_t;

  typedef enum logic [1:0] {
    TRIG_INIT, TRIG_FETCH, TRIG_READ, TRIG_NONE
  } cch_trig_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic          valid;
    cch_cmd_code_t code;
    logic [15:0]   label;
    logic [31:0]   arg;
  } cch_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        last;
    logic [31:0] data;
  } cch_resp_t;

  // ==========================================================
  // status bit positions, slot range, reset values
  localparam int          ESR_OPC_BIT    = 0;
  localparam int          ESR_EXE_BIT    = 4;
  localparam int          STB_ESB_BIT    = 5;
  localparam int          STB_MSS_BIT    = 6;
  localparam logic [7:0]  SLOT_MIN_SAVE  = 8'h01;
  localparam logic [7:0]  SLOT_MAX       = 8'h14;
  localparam logic [31:0] RESP_ASCII_ONE = 32'h0000_0031;
  localparam logic [7:0]  ESE_RESET      = 8'h00;
  localparam logic [7:0]  SRE_RESET      = 8'h00;
  localparam logic [7:0]  ESR_RESET      = 8'h00;

endpackage

// ===== cch_common_cmd.sv
`timescale 1ns/1ps
module cch_common_cmd #(
  parameter int          MACRO_SLOTS = 8,
  parameter logic [31:0] ID_CODE     = 32'h0000_a5a5  // arbitrary value
) (
  input  wire logic               clk_sys_i,
  input  wire logic               reset_n_i,
  input  wire cch_pkg::cch_cmd_t  cmd_i,
  output logic                    cmd_ready_o,
  output cch_pkg::cch_resp_t      resp_o,
  input  wire logic               meas_busy_i,
  input  wire logic [7:0]         event_set_i,
  input  wire logic [7:0]         stb_bits_i,
  input  wire logic [31:0]        opt_fitted_i,
  input  wire logic               cal_done_i,
  input  wire logic               cal_fail_i,
  input  wire logic               tst_done_i,
  input  wire logic [31:0]        tst_result_i,
  input  wire logic               nv_done_i,
  output logic                    cal_start_o,
  output logic                    tst_start_o,
  output logic                    nv_save_o,
  output logic                    nv_recall_o,
  output logic [7:0]              nv_slot_o,
  output logic                    dev_reset_o,
  output logic                    err_clear_o,
  output logic                    trig_init_o,
  output logic                    trig_fetch_o,
  output logic                    trig_read_o,
  output logic                    macro_en_o,
  output logic [1:0]              trig_action_o,
  output logic [7:0]              esr_o,
  output logic                    srq_o
);
  import cch_pkg::*;

  localparam int IW = $clog2(MACRO_SLOTS);

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_OPCQ, ST_CAL, ST_TST, ST_NV, ST_LIST
  } cch_state_t;

  // ==========================================================
  // state
  cch_state_t             state;
  cch_trig_t              ddt;
  logic [7:0]             ese;
  logic [7:0]             sre;
  logic [7:0]             esr;
  logic                   emc;
  logic                   opc_armed;
  logic [MACRO_SLOTS-1:0] mac_used;
  logic [15:0]            mac_label [MACRO_SLOTS];
  logic [31:0]            mac_body  [MACRO_SLOTS];
  logic [IW-1:0]          list_idx;

  // ==========================================================
  // decode
  logic        accept;
  logic        pending;
  logic        hit;
  logic        has_free;
  logic [IW-1:0] hit_idx;
  logic [IW-1:0] free_idx;
  logic        slot_bad;
  logic        dmc_full;
  logic [7:0]  esr_set;
  logic [7:0]  esr_clr;
  logic [7:0]  stb_now;

  // linear search shared by define and get
  function automatic logic [IW:0] find_slot(input logic want_used,
                                            input logic [15:0] lbl);
    logic [IW:0] r;
    r = '0;
    for (int i = MACRO_SLOTS - 1; i >= 0; i--) begin
      if (want_used ? (mac_used[i] && mac_label[i] == lbl) : !mac_used[i]) begin
        r = {1'b1, IW'(i)};
      end
    end
    return r;
  endfunction

  assign accept  = cmd_i.valid && cmd_ready_o;
  assign pending = meas_busy_i || state == ST_CAL || state == ST_TST || state == ST_NV;
  // a process, not an assign: the search reads the store, not only its arguments
  always_comb begin
    {hit, hit_idx}       = find_slot(1'b1, cmd_i.label);
    {has_free, free_idx} = find_slot(1'b0, cmd_i.label);
  end
  assign dmc_full = !hit && !has_free;
  assign slot_bad = (cmd_i.arg[31:8] != '0) || (cmd_i.arg[7:0] > SLOT_MAX)
                    || (cmd_i.code == CMD_SAV && cmd_i.arg[7:0] < SLOT_MIN_SAVE);

  // status byte: event summary and master summary formed from the enables
  always_comb begin
    stb_now              = stb_bits_i;
    stb_now[STB_ESB_BIT] = |(esr & ese);
    stb_now[STB_MSS_BIT] = 1'b0;
    stb_now[STB_MSS_BIT] = |(stb_now & sre & ~(8'h01 << STB_MSS_BIT));
  end

  always_comb begin
    esr_set = event_set_i;
    esr_clr = '0;
    if (opc_armed && !pending) begin
      esr_set[ESR_OPC_BIT] = 1'b1;
    end
    if (accept && (cmd_i.code == CMD_SAV || cmd_i.code == CMD_RCL) && slot_bad) begin
      esr_set[ESR_EXE_BIT] = 1'b1;
    end
    if (accept && cmd_i.code == CMD_DMC && dmc_full) begin
      esr_set[ESR_EXE_BIT] = 1'b1;
    end
    if (accept && (cmd_i.code == CMD_CLS || cmd_i.code == CMD_ESR_Q)) begin
      esr_clr = 8'hff;
    end
  end

  // ==========================================================
  // event status register: a new event wins over a clear
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      esr <= ESR_RESET;
    end else begin
      esr <= (esr & ~esr_clr) | esr_set;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      opc_armed <= 1'b0;
    end else if (accept && cmd_i.code == CMD_OPC) begin
      opc_armed <= 1'b1;
    end else if (!pending || (accept && cmd_i.code inside {CMD_CLS, CMD_RST})) begin
      opc_armed <= 1'b0;
    end
  end

  // ==========================================================
  // configuration: enables, trigger action, macro store
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ese <= ESE_RESET;
      sre <= SRE_RESET;
      ddt <= TRIG_INIT;
      emc <= 1'b0;
    end else if (accept) begin
      unique case (cmd_i.code)
        CMD_ESE: ese <= cmd_i.arg[7:0];
        CMD_SRE: sre <= cmd_i.arg[7:0];
        CMD_DDT: ddt <= cch_trig_t'(cmd_i.arg[1:0]);
        CMD_EMC: emc <= |cmd_i.arg;
        CMD_RST: begin
          ddt <= TRIG_INIT;
          emc <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // no reset on the bodies: only slots marked used are ever read
  always_ff @(posedge clk_sys_i) begin
    if (accept && cmd_i.code == CMD_DMC && !dmc_full) begin
      mac_label[hit ? hit_idx : free_idx] <= cmd_i.label;
      mac_body[hit ? hit_idx : free_idx]  <= cmd_i.arg;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mac_used <= '0;
    end else if (accept && cmd_i.code == CMD_PMC) begin
      mac_used <= '0;
    end else if (accept && cmd_i.code == CMD_DMC && !dmc_full) begin
      mac_used[hit ? hit_idx : free_idx] <= 1'b1;
    end
  end

  // ==========================================================
  // sequencer: command acceptance, responses and side pulses
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state        <= ST_IDLE;
      cmd_ready_o  <= 1'b0;
      resp_o       <= '0;
      cal_start_o  <= 1'b0;
      tst_start_o  <= 1'b0;
      nv_save_o    <= 1'b0;
      nv_recall_o  <= 1'b0;
      nv_slot_o    <= '0;
      dev_reset_o  <= 1'b0;
      err_clear_o  <= 1'b0;
      trig_init_o  <= 1'b0;
      trig_fetch_o <= 1'b0;
      trig_read_o  <= 1'b0;
      list_idx     <= '0;
    end else begin
      resp_o       <= '0;
      cal_start_o  <= 1'b0;
      tst_start_o  <= 1'b0;
      nv_save_o    <= 1'b0;
      nv_recall_o  <= 1'b0;
      dev_reset_o  <= 1'b0;
      err_clear_o  <= 1'b0;
      trig_init_o  <= 1'b0;
      trig_fetch_o <= 1'b0;
      trig_read_o  <= 1'b0;
      // one idle cycle between commands keeps decode and store simple
      cmd_ready_o  <= state == ST_IDLE && !accept;
      unique case (state)
        ST_IDLE: begin
          if (accept) begin
            resp_o.last <= 1'b1;
            unique case (cmd_i.code)
              CMD_CAL_Q: begin
                cal_start_o <= 1'b1;
                state       <= ST_CAL;
              end
              CMD_TST_Q: begin
                tst_start_o <= 1'b1;
                state       <= ST_TST;
              end
              CMD_SAV, CMD_RCL: begin
                if (!slot_bad) begin
                  nv_save_o   <= cmd_i.code == CMD_SAV;
                  nv_recall_o <= cmd_i.code == CMD_RCL;
                  nv_slot_o   <= cmd_i.arg[7:0];
                  state       <= ST_NV;
                end
              end
              CMD_CLS: err_clear_o <= 1'b1;
              CMD_RST: dev_reset_o <= 1'b1;
              CMD_TRG, CMD_GET: begin
                trig_init_o  <= ddt == TRIG_INIT;
                trig_fetch_o <= ddt == TRIG_FETCH;
                trig_read_o  <= ddt == TRIG_READ;
              end
              CMD_WAI: state <= ST_WAIT;
              CMD_OPC_Q: state <= ST_OPCQ;
              CMD_EMC_Q: resp_o <= '{1'b1, 1'b1, {31'h0, emc}};
              CMD_ESE_Q: resp_o <= '{1'b1, 1'b1, {24'h0, ese}};
              CMD_SRE_Q: resp_o <= '{1'b1, 1'b1, {24'h0, sre}};
              CMD_ESR_Q: resp_o <= '{1'b1, 1'b1, {24'h0, esr}};
              CMD_STB_Q: resp_o <= '{1'b1, 1'b1, {24'h0, stb_now}};
              CMD_IDN_Q: resp_o <= '{1'b1, 1'b1, ID_CODE};
              CMD_OPT_Q: resp_o <= '{1'b1, 1'b1, opt_fitted_i};
              CMD_GMC_Q: resp_o <= '{1'b1, 1'b1, hit ? mac_body[hit_idx] : 32'h0};
              CMD_LMC_Q: begin
                list_idx <= '0;
                state    <= ST_LIST;
              end
              default: ;
            endcase
          end
        end
        ST_WAIT: begin
          if (!meas_busy_i) begin
            state <= ST_IDLE;
          end
        end
        ST_OPCQ: begin
          if (!meas_busy_i) begin
            resp_o <= '{1'b1, 1'b1, RESP_ASCII_ONE};
            state  <= ST_IDLE;
          end
        end
        ST_CAL: begin
          if (cal_done_i) begin
            resp_o <= '{1'b1, 1'b1, {31'h0, cal_fail_i}};
            state  <= ST_IDLE;
          end
        end
        ST_TST: begin
          if (tst_done_i) begin
            resp_o <= '{1'b1, 1'b1, tst_result_i};
            state  <= ST_IDLE;
          end
        end
        ST_NV: begin
          if (nv_done_i) begin
            state <= ST_IDLE;
          end
        end
        ST_LIST: begin
          // one word per defined label; an empty store answers a single zero word
          resp_o.valid <= mac_used[list_idx] || (list_idx == IW'(MACRO_SLOTS - 1)
                          && mac_used == '0);
          resp_o.data  <= mac_used[list_idx] ? {16'h0, mac_label[list_idx]} : 32'h0;
          // last marks the highest used slot, so a partly filled store still ends
          resp_o.last  <= (mac_used >> list_idx) == MACRO_SLOTS'(1)
                          || list_idx == IW'(MACRO_SLOTS - 1);
          list_idx     <= list_idx + IW'(1);
          if (list_idx == IW'(MACRO_SLOTS - 1)) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // registered status outputs
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      macro_en_o    <= 1'b0;
      trig_action_o <= '0;
      esr_o         <= '0;
      srq_o         <= 1'b0;
    end else begin
      macro_en_o    <= emc;
      trig_action_o <= ddt;
      esr_o         <= esr;
      srq_o         <= stb_now[STB_MSS_BIT];
    end
  end

endmodule

// ===== cch_engine_model.sv
`timescale 1ns/1ps
// ==========================================================
// back-end engine: answers each start pulse after delay_i cycles
module cch_engine_model (
  input  wire logic       clk_sys_i,
  input  wire logic       start_i,
  input  wire logic [7:0] delay_i,
  output logic            done_o
);
  logic [7:0] cnt = 8'h00;
  initial done_o = 1'b0;
  // delay_i is taken at start, so the bench may vary prompt and slow answers
  always @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    if (start_i) begin
      cnt <= delay_i;
    end else if (cnt != 8'h00) begin
      cnt    <= cnt - 8'h01;
      done_o <= (cnt == 8'h01);
    end
  end
endmodule

// ===== cch_common_cmd_assertions.sv
`timescale 1ns/1ps
module cch_common_cmd_assertions
  import cch_pkg::*;
(
  input wire logic               clk_sys_i,
  input wire logic               reset_n_i,
  input wire cch_pkg::cch_cmd_t  cmd_i,
  input wire logic               cmd_ready_o,
  input wire cch_pkg::cch_resp_t resp_o,
  input wire logic               meas_busy_i,
  input wire logic               cal_done_i,
  input wire logic               cal_fail_i,
  input wire logic               cal_start_o,
  input wire logic               nv_save_o,
  input wire logic               nv_recall_o,
  input wire logic [7:0]         nv_slot_o,
  input wire logic               dev_reset_o,
  input wire logic               err_clear_o,
  input wire logic               trig_init_o,
  input wire logic               macro_en_o,
  input wire logic [1:0]         trig_action_o,
  input wire logic [7:0]         esr_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================================
  // helpers
  logic        take;
  logic        wai_p;
  logic        opc_p;
  logic        cal_p;
  logic [31:0] a;
  logic [31:0] tk;
  assign take = cmd_i.valid && cmd_ready_o;
  assign a    = cmd_i.arg;
  // one bit per taken code: a vector is sampled, signals read inside a function are not
  assign tk   = take ? (32'h1 << cmd_i.code) : 32'h0;
  // pending flags stand in for the design's hidden wait states
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) wai_p <= 1'b0;
    else if (tk[CMD_WAI]) wai_p <= 1'b1;
    else if (!meas_busy_i) wai_p <= 1'b0;
  end
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) opc_p <= 1'b0;
    else if (tk[CMD_OPC_Q]) opc_p <= 1'b1;
    else if (resp_o.valid) opc_p <= 1'b0;
  end
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) cal_p <= 1'b0;
    else if (cal_start_o) cal_p <= 1'b1;
    else if (cal_done_i) cal_p <= 1'b0;
  end
  // ==========================================================
  // properties
  AST_CAL_GO: assert property (tk[CMD_CAL_Q] |=> cal_start_o)
    else $error("calibration not started");
  AST_CAL_ANS: assert property (cal_p && cal_done_i |=> resp_o.valid &&
    resp_o.data == {31'h0, $past(cal_fail_i)}) else $error("calibration answer wrong");
  AST_CLS: assert property (tk[CMD_CLS] |-> ##[1:2] err_clear_o)
    else $error("error queue not cleared");
  AST_EMC: assert property (tk[CMD_EMC] |-> ##2 macro_en_o == ($past(a, 2) != 32'h0))
    else $error("macro enable wrong");
  AST_TRG: assert property (tk[CMD_TRG] && trig_action_o == TRIG_INIT |-> ##[1:2] trig_init_o)
    else $error("trigger did not initiate");
  AST_SAV_BAD: assert property (tk[CMD_SAV] && (a == 32'h0 || a > 32'h14) |=>
    !nv_save_o ##[1:2] esr_o[ESR_EXE_BIT]) else $error("bad save slot not refused");
  AST_SAV_OK: assert property (tk[CMD_SAV] && a != 32'h0 && a <= 32'h14 |=>
    nv_save_o && nv_slot_o == $past(a[7:0])) else $error("save not issued");
  AST_RCL: assert property (tk[CMD_RCL] && a <= 32'h14 |=>
    nv_recall_o && nv_slot_o == $past(a[7:0])) else $error("recall not issued");
  AST_RST: assert property (tk[CMD_RST] |-> ##[1:2] dev_reset_o)
    else $error("reset pulse missing");
  AST_WAI: assert property (wai_p && meas_busy_i |-> !cmd_ready_o)
    else $error("command taken while waiting");
  AST_OPC_HOLD: assert property (opc_p && meas_busy_i |=> !resp_o.valid)
    else $error("completion answered while busy");
  AST_OPC_ONE: assert property (opc_p && resp_o.valid |-> resp_o.data == RESP_ASCII_ONE)
    else $error("completion answer wrong");
  cover property (tk[CMD_WAI] && meas_busy_i);
  cover property (cal_p && cal_done_i);
  cover property (opc_p && resp_o.valid);
endmodule
bind cch_common_cmd cch_common_cmd_assertions u_chk (.clk_sys_i, .reset_n_i, .cmd_i,
  .cmd_ready_o, .resp_o, .meas_busy_i, .cal_done_i, .cal_fail_i, .cal_start_o, .nv_save_o,
  .nv_recall_o, .nv_slot_o, .dev_reset_o, .err_clear_o, .trig_init_o, .macro_en_o,
  .trig_action_o, .esr_o);

// ===== cch_common_cmd_tb.sv
`timescale 1ns/1ps
module cch_common_cmd_tb;
  import cch_pkg::*;
  localparam logic [31:0] ID = 32'h0000_5a5a;  // arbitrary value
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, busy = 1'b0, fail = 1'b0;
  cch_cmd_t    cmd = '0;
  cch_resp_t   resp;
  logic [7:0]  evs = 8'h00, dly = 8'h03, slot, esr;
  logic [1:0]  tact;
  logic        cg, tg, sv, rc, cd, td, nd, rdy, mac, dres, eclr, ti, tf, tr, srq;
  int          n_errors = 0, n_compared = 0, n_ini = 0, n_fet = 0, n_rd = 0, n_clr = 0;
  int          n_rst = 0, n_sav = 0;
  time         t_ans, t_rel;
  always #4 clk_sys_i = ~clk_sys_i;
  cch_common_cmd #(.ID_CODE(ID)) DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cmd_i(cmd),
    .cmd_ready_o(rdy), .resp_o(resp), .meas_busy_i(busy), .event_set_i(evs),
    .stb_bits_i(8'h00), .opt_fitted_i(32'h0000_0003), .cal_done_i(cd), .cal_fail_i(fail),
    .tst_done_i(td), .tst_result_i(32'h0000_00a0), .nv_done_i(nd), .cal_start_o(cg),
    .tst_start_o(tg), .nv_save_o(sv), .nv_recall_o(rc), .nv_slot_o(slot), .dev_reset_o(dres),
    .err_clear_o(eclr), .trig_init_o(ti), .trig_fetch_o(tf), .trig_read_o(tr),
    .macro_en_o(mac), .trig_action_o(tact), .esr_o(esr), .srq_o(srq));
  cch_engine_model u_cal (.clk_sys_i(clk_sys_i), .start_i(cg), .delay_i(dly), .done_o(cd));
  cch_engine_model u_tst (.clk_sys_i(clk_sys_i), .start_i(tg), .delay_i(dly), .done_o(td));
  cch_engine_model u_nv (.clk_sys_i(clk_sys_i), .start_i(sv | rc), .delay_i(dly), .done_o(nd));
  // ==========================================================
  // pulse counters
  always @(posedge clk_sys_i) begin
    n_ini += (ti === 1'b1);
    n_fet += (tf === 1'b1);
    n_rd  += (tr === 1'b1);
    n_clr += (eclr === 1'b1);
    n_rst += (dres === 1'b1);
    n_sav += (sv === 1'b1);
  end
  // ==========================================================
  // access tasks
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input cch_cmd_code_t c, input logic [31:0] a, input logic [15:0] l = 16'h0);
    int i = 0;
    @(posedge clk_sys_i);
    cmd <= {1'b1, c, l, a};
    do @(posedge clk_sys_i); while (rdy !== 1'b1 && ++i < 500);
    if (i >= 500) n_errors++;
    cmd <= '0;
  endtask
  task automatic nxt(input logic [32:0] exp);
    int i = 0;
    do @(posedge clk_sys_i); while (resp.valid !== 1'b1 && ++i < 500);
    if (i >= 500) n_errors++;
    t_ans = $time;
    check({resp.last, resp.data}, exp);
  endtask
  task automatic query(input cch_cmd_code_t c, input logic [32:0] exp, input logic [15:0] l = 16'h0);
    send(c, 32'h0, l);
    nxt(exp);
  endtask
  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_errors++;
    finish_test();
  end
  // ==========================================================
  // sequence
  initial begin
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    send(CMD_ESE, 32'h04);
    send(CMD_SRE, 32'h20);
    query(CMD_ESE_Q, 33'h1_0000_0004);
    query(CMD_SRE_Q, 33'h1_0000_0020);
    evs <= 8'h04;
    @(posedge clk_sys_i);
    evs <= 8'h00;
    query(CMD_STB_Q, 33'h1_0000_0060);
    check(srq, 1'b1);
    query(CMD_ESR_Q, 33'h1_0000_0004);
    evs <= 8'h08;
    @(posedge clk_sys_i);
    evs <= 8'h00;
    send(CMD_CLS, 32'h0);
    query(CMD_ESR_Q, 33'h1_0000_0000);
    check(srq, 1'b0);
    check(n_clr, 1);
    send(CMD_EMC, 32'h5);
    query(CMD_EMC_Q, 33'h1_0000_0001);
    send(CMD_EMC, 32'h0);
    query(CMD_EMC_Q, 33'h1_0000_0000);
    send(CMD_DMC, 32'hdead_0001, 16'h1111);
    send(CMD_DMC, 32'hbeef_0002, 16'h2222);
    query(CMD_GMC_Q, 33'h1_dead_0001, 16'h1111);
    query(CMD_LMC_Q, 33'h0_0000_1111);
    nxt(33'h1_0000_2222);
    send(CMD_PMC, 32'h0);
    query(CMD_LMC_Q, 33'h1_0000_0000);
    for (int k = 0; k < 4; k++) begin
      send(CMD_DDT, k);
      send(CMD_TRG, 32'h0);
    end
    send(CMD_DDT, 32'h0);
    send(CMD_GET, 32'h0);
    send(CMD_ESE, 32'h04);
    check(33'(n_ini), 33'd2);
    check(33'(n_fet), 33'd1);
    check(33'(n_rd), 33'd1);
    busy <= 1'b1;
    fork
      query(CMD_OPC_Q, {1'b1, RESP_ASCII_ONE});
      begin
        repeat (20) @(posedge clk_sys_i);
        t_rel = $time;
        busy <= 1'b0;
      end
    join
    check(t_ans > t_rel, 1);
    busy <= 1'b1;
    send(CMD_OPC, 32'h0);
    query(CMD_ESR_Q, 33'h1_0000_0000);
    busy <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    query(CMD_ESR_Q, 33'h1_0000_0001);
    busy <= 1'b1;
    fork
      begin
        send(CMD_WAI, 32'h0);
        query(CMD_ESE_Q, 33'h1_0000_0004);
      end
      begin
        repeat (25) @(posedge clk_sys_i);
        t_rel = $time;
        busy <= 1'b0;
      end
    join
    check(t_ans > t_rel, 1);
    fail <= 1'b1;
    query(CMD_CAL_Q, 33'h1_0000_0001);
    fail <= 1'b0;
    dly <= 8'h40;
    query(CMD_CAL_Q, 33'h1_0000_0000);
    query(CMD_TST_Q, 33'h1_0000_00a0);
    query(CMD_IDN_Q, {1'b1, ID});
    query(CMD_OPT_Q, 33'h1_0000_0003);
    dly <= 8'h02;
    send(CMD_SAV, 32'h0);
    query(CMD_ESR_Q, 33'h1_0000_0010);
    send(CMD_SAV, 32'h14);
    send(CMD_RCL, 32'h15);
    query(CMD_ESR_Q, 33'h1_0000_0010);
    check(33'(n_sav), 33'd1);
    check(slot, 8'h14);
    send(CMD_RCL, 32'h0);
    send(CMD_DDT, 32'h3);
    send(CMD_EMC, 32'h1);
    send(CMD_RST, 32'h0);
    check(slot, 8'h00);
    repeat (3) @(posedge clk_sys_i);
    check(tact, 2'h0);
    check(mac, 1'b0);
    check(33'(n_rst), 33'd1);
    finish_test();
  end
endmodule
